// ### src/ilrm_rx_error_monitor.v
/*
  Receive status and error monitor: per-lane meta frame and framing
  error pulses, lane word lock, deskew state and failure, control word
  check, burst rule checks and per-channel packet delineation repair,
  with a two-entry buffer toward the user receive logic.
  Assumes decoded lane events and decoded control/data words arrive
  synchronous to clk_in, at most one word per cycle, and that the
  source holds a word while word_ready_out is low.
*/
// Notes on behaviour
// - Per lane, pulse meta frame word error on bad sync word when locked.
// - Lanes-deskewed high only when all lanes aligned, locked and receiver ready.
// - Raise deskew failure after repeated failed alignment attempts.
// - Raise deskew failure when lanes-deskewed falls after being high.
// - Per locked lane, pulse framing error once per illegal framing pattern.
// - Framing error after alignment is handled as a control word check error.
// - Pulse control word check error when received CRC24 differs from computed.
// - On a check error mark all open packets errored, no attribution.
// - Data for a channel without open packet pulses missing-start error.
// - Missing start: insert SOP before data, flag packet error at EOP.
// - SOP on channel with packet still open pulses missing-end error.
// - Missing end: drop extra SOP, merge packets, flag error at EOP.
// - Every delivered packet begins with SOP and ends with EOP.
// - Pulse burst rule error on spacing or length violation.
// - Burst rule violation marks all open packets errored like CRC24.
// - Spacing violation when burst control words closer than BurstShort.
// - Length violation when non-EOP burst not a multiple of bus width.
// - All status outputs update on the rising clock edge.
// - Word lock high only while lane synced and control words as expected.
// - Burst length counts 64-bit data words between control words.
`include "ilrm_defines.vh"

module ilrm_buf2 #(
  parameter W = 8
) (
  input  wire         clk_in,
  input  wire         nrst_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg  [W-1:0] ent0_q;
  reg  [W-1:0] ent1_q;
  reg  [1:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready_out  = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out  = ent0_q;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Entry 0 is the head; entry 1 only holds a word while the head stalls
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ent0_q <= {W{1'b0}};
      ent1_q <= {W{1'b0}};
      cnt_q  <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) begin
            ent0_q <= in_data_in;
          end else begin
            ent1_q <= in_data_in;
          end
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          ent0_q <= ent1_q;
          cnt_q  <= cnt_q - 2'h1;
        end
        2'b11: begin
          if (cnt_q == 2'h1) begin
            ent0_q <= in_data_in;
          end else begin
            ent0_q <= ent1_q;
            ent1_q <= in_data_in;
          end
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end
endmodule // ilrm_buf2

module ilrm_rx_error_monitor (
  input  wire                        clk_in,
  input  wire                        nrst_in,
  // Lane side
  input  wire [`ILRM_LANES-1:0]      lane_boundary_sync_in,
  input  wire [`ILRM_LANES-1:0]      lane_ctl_words_ok_in,
  input  wire [`ILRM_LANES-1:0]      lane_sync_word_bad_in,
  input  wire [`ILRM_LANES-1:0]      lane_framing_bad_in,
  input  wire                        lanes_deskew_done_in,
  input  wire                        align_attempt_fail_in,
  input  wire                        rx_enable_in,
  // Configuration
  input  wire [`ILRM_BSHORT_W-1:0]   burst_short_bytes_in,
  // Decoded word stream
  input  wire                        ctl_valid_in,
  input  wire                        ctl_burst_in,
  input  wire                        ctl_sop_in,
  input  wire                        ctl_eop_in,
  input  wire [`ILRM_CHAN_W-1:0]     ctl_chan_in,
  input  wire [23:0]                 ctl_crc_rcvd_in,
  input  wire [23:0]                 ctl_crc_calc_in,
  input  wire                        data_valid_in,
  input  wire [`ILRM_WORD_W-1:0]     data_word_in,
  output wire                        word_ready_out,
  // Local bus receive side
  output wire                        local_bus_valid_out,
  input  wire                        local_bus_ready_in,
  output wire [`ILRM_WORD_W-1:0]     local_bus_data_out,
  output wire [`ILRM_CHAN_W-1:0]     local_bus_chan_out,
  output wire                        local_bus_sop_out,
  output wire                        local_bus_eop_out,
  output wire                        packet_error_out,
  // Status
  output reg  [`ILRM_LANES-1:0]      lane_word_locked_out,
  output reg  [`ILRM_LANES-1:0]      metaframe_word_error_out,
  output reg  [`ILRM_LANES-1:0]      framing_error_out,
  output reg                         lanes_deskewed_out,
  output reg                         deskew_failure_out,
  output reg                         control_word_check_error_out,
  output reg                         missing_start_error_out,
  output reg                         missing_end_error_out,
  output reg                         burst_rule_error_out
);
  reg  [`ILRM_NCHAN-1:0]   open_q;
  reg  [`ILRM_NCHAN-1:0]   open_d;
  reg  [`ILRM_NCHAN-1:0]   err_q;
  reg  [`ILRM_NCHAN-1:0]   err_d;
  reg  [`ILRM_CHAN_W-1:0]  cur_ch_q;
  reg  [`ILRM_NCHAN-1:0]   sopp_q;
  reg                      pend_v_q;
  reg                      pend_sop_q;
  reg  [`ILRM_WORD_W-1:0]  pend_data_q;
  reg  [`ILRM_CNT_W-1:0]   gap_q;
  reg  [`ILRM_CNT_W-1:0]   blen_q;
  reg                      seen_bcw_q;
  reg  [`ILRM_TRIES_W-1:0] tries_q;
  reg                      msop_d;
  reg                      meop_d;
  reg                      push_d;
  reg  [`ILRM_ENT_W-1:0]   ent_d;
  wire                     buf_ready;
  wire [`ILRM_ENT_W-1:0]   buf_out;
  wire                     ctl_acc;
  wire                     data_acc;
  wire                     crc_bad;
  wire                     frame_bad;
  wire                     spacing_bad;
  wire                     length_bad;
  wire                     burst_bad;
  wire                     mark_all;
  wire                     deskewed_d;
  wire [`ILRM_CNT_W-1:0]   min_gap;

  // Control words take priority if a source ever offers both at once
  assign word_ready_out = buf_ready;
  assign ctl_acc        = ctl_valid_in & buf_ready;
  assign data_acc       = data_valid_in & ~ctl_valid_in & buf_ready;

  assign crc_bad   = ctl_acc & (ctl_crc_rcvd_in != ctl_crc_calc_in);
  assign frame_bad = lanes_deskewed_out & (|(lane_framing_bad_in & lane_word_locked_out));

  assign min_gap     = burst_short_bytes_in >> `ILRM_BYTES_SHIFT;
  assign spacing_bad = ctl_acc & ctl_burst_in & seen_bcw_q & (gap_q < min_gap);
  assign length_bad  = ctl_acc & ~ctl_eop_in & (blen_q[`ILRM_BUS_MOD_MSB:0] != 3'h0);
  assign burst_bad   = spacing_bad | length_bad;

  // Every check failure poisons all open packets
  assign mark_all = crc_bad | frame_bad | burst_bad;

  // Deskewed needs all lanes locked and the receiver enabled
  assign deskewed_d = lanes_deskew_done_in & (&lane_word_locked_out) & rx_enable_in;

  // Packet state and what goes into the buffer this cycle
  always @* begin
    open_d = open_q;
    err_d  = err_q;
    msop_d = 1'b0;
    meop_d = 1'b0;
    push_d = 1'b0;
    ent_d  = {`ILRM_ENT_W{1'b0}};
    ent_d[`ILRM_F_CHAN_LSB +: `ILRM_CHAN_W] = cur_ch_q;
    ent_d[`ILRM_F_DATA_LSB +: `ILRM_WORD_W] = pend_data_q;
    ent_d[`ILRM_F_SOP] = pend_sop_q;
    if (ctl_acc) begin
      // Held last word of the burst leaves now, tagged EOP if this word says so
      push_d = pend_v_q;
      if (ctl_eop_in) begin
        // Error shows with the EOP of the repaired packet
        ent_d[`ILRM_F_EOP] = 1'b1;
        ent_d[`ILRM_F_ERR] = err_q[cur_ch_q] | mark_all;
        open_d[cur_ch_q]   = 1'b0;
        err_d[cur_ch_q]    = 1'b0;
      end
      if (ctl_sop_in) begin
        if (open_d[ctl_chan_in]) begin
          // Drop the surplus SOP and merge
          meop_d = 1'b1;
          err_d[ctl_chan_in] = 1'b1;
        end else begin
          open_d[ctl_chan_in] = 1'b1;
        end
      end
    end else if (data_acc) begin
      push_d = pend_v_q;
      if (!open_q[cur_ch_q]) begin
        // Orphan data gets an inserted SOP
        msop_d = 1'b1;
        open_d[cur_ch_q] = 1'b1;
        err_d[cur_ch_q]  = 1'b1;
      end
    end
    if (mark_all) begin
      err_d = err_d | open_d;
    end
  end

  // Words reach the user side only through the SOP/EOP repair above
  ilrm_buf2 #(
    .W (`ILRM_ENT_W)
  ) u_buf (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (push_d),
    .in_ready_out  (buf_ready),
    .in_data_in    (ent_d),
    .out_valid_out (local_bus_valid_out),
    .out_ready_in  (local_bus_ready_in),
    .out_data_out  (buf_out)
  );

  assign local_bus_data_out = buf_out[`ILRM_F_DATA_LSB +: `ILRM_WORD_W];
  assign local_bus_chan_out = buf_out[`ILRM_F_CHAN_LSB +: `ILRM_CHAN_W];
  assign local_bus_sop_out  = buf_out[`ILRM_F_SOP];
  assign local_bus_eop_out  = buf_out[`ILRM_F_EOP];
  assign packet_error_out   = buf_out[`ILRM_F_ERR];

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      open_q      <= `ILRM_RST_CHANS;
      err_q       <= `ILRM_RST_CHANS;
      cur_ch_q    <= {`ILRM_CHAN_W{1'b0}};
      sopp_q      <= `ILRM_RST_CHANS;
      pend_v_q    <= 1'b0;
      pend_sop_q  <= 1'b0;
      pend_data_q <= {`ILRM_WORD_W{1'b0}};
    end else begin
      open_q <= open_d;
      err_q  <= err_d;
      if (ctl_acc) begin
        pend_v_q <= 1'b0;
        if (ctl_burst_in) begin
          cur_ch_q <= ctl_chan_in;
        end
        // A kept SOP waits per channel, so a second burst control word before data cannot lose it
        if (ctl_sop_in & ~meop_d) begin
          sopp_q[ctl_chan_in] <= 1'b1;
        end
      end else if (data_acc) begin
        pend_v_q         <= 1'b1;
        pend_data_q      <= data_word_in;
        pend_sop_q       <= sopp_q[cur_ch_q] | msop_d;
        sopp_q[cur_ch_q] <= 1'b0;
      end
    end
  end

  // Burst length in data words; spacing in words between burst control words
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_q      <= {`ILRM_CNT_W{1'b0}};
      blen_q     <= {`ILRM_CNT_W{1'b0}};
      seen_bcw_q <= 1'b0;
    end else begin
      if (ctl_acc) begin
        blen_q <= {`ILRM_CNT_W{1'b0}};
        if (ctl_burst_in) begin
          gap_q      <= {`ILRM_CNT_W{1'b0}};
          seen_bcw_q <= 1'b1;
        end else if (gap_q != `ILRM_CNT_MAX) begin
          gap_q <= gap_q + 9'h001;
        end
      end else if (data_acc) begin
        if (blen_q != `ILRM_CNT_MAX) begin
          blen_q <= blen_q + 9'h001;
        end
        if (gap_q != `ILRM_CNT_MAX) begin
          gap_q <= gap_q + 9'h001;
        end
      end
    end
  end

  // All status outputs registered on the rising edge
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lane_word_locked_out         <= `ILRM_RST_LANES;
      metaframe_word_error_out     <= `ILRM_RST_LANES;
      framing_error_out            <= `ILRM_RST_LANES;
      lanes_deskewed_out           <= 1'b0;
      deskew_failure_out           <= 1'b0;
      control_word_check_error_out <= 1'b0;
      missing_start_error_out      <= 1'b0;
      missing_end_error_out        <= 1'b0;
      burst_rule_error_out         <= 1'b0;
      tries_q                      <= {`ILRM_TRIES_W{1'b0}};
    end else begin
      // Lock needs boundary sync and expected sync/scrambler words
      lane_word_locked_out <= lane_boundary_sync_in & lane_ctl_words_ok_in;
      // Only locked lanes report bad sync words
      metaframe_word_error_out <= lane_sync_word_bad_in & lane_word_locked_out;
      // One pulse per illegal framing pattern
      framing_error_out <= lane_framing_bad_in & lane_word_locked_out;
      lanes_deskewed_out <= deskewed_d;
      // Attempt counter saturates; cleared once aligned
      if (lanes_deskewed_out) begin
        tries_q <= {`ILRM_TRIES_W{1'b0}};
      end else if (align_attempt_fail_in && tries_q != `ILRM_ALIGN_TRIES) begin
        tries_q <= tries_q + 3'h1;
      end
      // Exhausted attempts hold high; loss of alignment pulses
      deskew_failure_out <= (tries_q == `ILRM_ALIGN_TRIES) |
                            (lanes_deskewed_out & ~deskewed_d);
      // Framing after alignment reports as a check error
      control_word_check_error_out <= crc_bad | frame_bad;
      missing_start_error_out <= msop_d;
      missing_end_error_out <= meop_d;
      burst_rule_error_out <= burst_bad;
    end
  end
endmodule // ilrm_rx_error_monitor

// ### src/ilrm_defines.vh
/*
  Constants for the receive error monitor: sizes, field positions,
  reset values and limits. Included by the monitor design file only.
*/
`ifndef ILRM_DEFINES_VH
`define ILRM_DEFINES_VH

// Lane count and channel address width
`define ILRM_LANES        12
`define ILRM_CHAN_W       4
`define ILRM_NCHAN        16

// Data word width (one Interlaken data word)
`define ILRM_WORD_W       64

// Local bus width in data words (512-bit bus)
`define ILRM_BUS_WORDS    4'h8
`define ILRM_BUS_MOD_MSB  2

// Burst counters and BurstShort (bytes) widths
`define ILRM_CNT_W        9
`define ILRM_CNT_MAX      9'h1FF
`define ILRM_BSHORT_W     9
`define ILRM_BYTES_SHIFT  3

// Failed alignment attempts before the failure output is raised
`define ILRM_TRIES_W      3
`define ILRM_ALIGN_TRIES  3'h4

// Buffer entry layout: {eop, err, sop, chan, data}
`define ILRM_ENT_W        (`ILRM_WORD_W + `ILRM_CHAN_W + 3)
`define ILRM_F_DATA_LSB   0
`define ILRM_F_CHAN_LSB   `ILRM_WORD_W
`define ILRM_F_SOP        (`ILRM_WORD_W + `ILRM_CHAN_W)
`define ILRM_F_ERR        (`ILRM_WORD_W + `ILRM_CHAN_W + 1)
`define ILRM_F_EOP        (`ILRM_WORD_W + `ILRM_CHAN_W + 2)

// Reset values
`define ILRM_RST_LANES    12'h000
`define ILRM_RST_CHANS    16'h0000

`endif

// ### verification/ilrm_assertions.sv
/* Concurrent checks on the receive error monitor ports.
   Assumes one clock domain and an asynchronous active-low reset. */
module ilrm_chk (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [11:0] lane_boundary_sync_in,
  input wire logic [11:0] lane_ctl_words_ok_in,
  input wire logic [11:0] lane_sync_word_bad_in,
  input wire logic [11:0] lane_framing_bad_in,
  input wire logic        lanes_deskew_done_in,
  input wire logic        rx_enable_in,
  input wire logic        ctl_valid_in,
  input wire logic        ctl_sop_in,
  input wire logic [23:0] ctl_crc_rcvd_in,
  input wire logic [23:0] ctl_crc_calc_in,
  input wire logic        data_valid_in,
  input wire logic        word_ready_out,
  input wire logic        local_bus_valid_out,
  input wire logic        local_bus_ready_in,
  input wire logic [63:0] local_bus_data_out,
  input wire logic        local_bus_eop_out,
  input wire logic [11:0] lane_word_locked_out,
  input wire logic [11:0] metaframe_word_error_out,
  input wire logic [11:0] framing_error_out,
  input wire logic        lanes_deskewed_out,
  input wire logic        deskew_failure_out,
  input wire logic        control_word_check_error_out,
  input wire logic        missing_start_error_out,
  input wire logic        missing_end_error_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_bad_ctl;
    ctl_valid_in && word_ready_out && (ctl_crc_rcvd_in != ctl_crc_calc_in);
  endsequence
  sequence s_stall;
    local_bus_valid_out && !local_bus_ready_in;
  endsequence
  property p_lock;
    $past(nrst_in) |-> lane_word_locked_out == $past(lane_boundary_sync_in & lane_ctl_words_ok_in);
  endproperty
  a_lock: assert property (p_lock) else $error("word lock mismatch");
  property p_mf;
    $past(nrst_in) |-> metaframe_word_error_out == $past(lane_sync_word_bad_in & lane_word_locked_out);
  endproperty
  a_mf: assert property (p_mf) else $error("meta frame error pulse wrong");
  property p_fr;
    $past(nrst_in) |-> framing_error_out == $past(lane_framing_bad_in & lane_word_locked_out);
  endproperty
  a_fr: assert property (p_fr) else $error("framing error pulse wrong");
  property p_dsk;
    $past(nrst_in) |-> lanes_deskewed_out ==
      ($past(lanes_deskew_done_in && rx_enable_in) && (&$past(lane_word_locked_out)));
  endproperty
  a_dsk: assert property (p_dsk) else $error("deskewed level wrong");
  property p_loss;
    $fell(lanes_deskewed_out) |-> ##[0:1] deskew_failure_out;
  endproperty
  a_loss: assert property (p_loss) else $error("no failure on alignment loss");
  property p_crc;
    s_bad_ctl |=> control_word_check_error_out;
  endproperty
  a_crc: assert property (p_crc) else $error("check error not pulsed");
  property p_msop;
    missing_start_error_out |-> $past(data_valid_in && !ctl_valid_in && word_ready_out);
  endproperty
  a_msop: assert property (p_msop) else $error("missing start without data");
  property p_meop;
    missing_end_error_out |-> $past(ctl_valid_in && ctl_sop_in && word_ready_out);
  endproperty
  a_meop: assert property (p_meop) else $error("missing end without start");
  property p_hold;
    s_stall |=> local_bus_valid_out && $stable(local_bus_data_out) && $stable(local_bus_eop_out);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
endmodule // ilrm_chk

bind ilrm_rx_error_monitor ilrm_chk chk_u (.*);

// ### verification/ilrm_user_sink.sv
/* User receive logic model: takes local bus words with random stalls.
   Assumes the bench may hold it off entirely to fill the buffer. */
module ilrm_user_sink (
  input  wire logic clk_in,
  input  wire logic stall_in,
  output logic      ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ready_out = 1'b0;
  // Random back-pressure exercises the buffer's hold path
  always @(posedge clk_in) begin
    ready_out <= !stall_in && ($urandom % 4 != 0);
  end
endmodule // ilrm_user_sink

// ### verification/ilrm_rx_error_monitor_tb.sv
/* Self-checking bench of the receive error monitor.
   Assumes the design, its checker and the user sink model are compiled first. */
module ilrm_rx_error_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, nrst_in = 0, lanes_deskew_done_in = 0, align_attempt_fail_in = 0, rx_enable_in = 0;
  logic [11:0] lane_boundary_sync_in = 0, lane_ctl_words_ok_in = 0, lane_sync_word_bad_in = 0;
  logic [11:0] lane_framing_bad_in = 0;
  logic [8:0] burst_short_bytes_in = 0;
  logic ctl_valid_in = 0, ctl_burst_in = 0, ctl_sop_in = 0, ctl_eop_in = 0, data_valid_in = 0, stall = 0;
  logic [3:0] ctl_chan_in = 0;
  logic [23:0] ctl_crc_rcvd_in = 0, ctl_crc_calc_in = 0;
  logic [63:0] data_word_in = 0;
  logic local_bus_ready_in;
  wire word_ready_out, local_bus_valid_out, local_bus_sop_out, local_bus_eop_out, packet_error_out;
  wire lanes_deskewed_out, deskew_failure_out, control_word_check_error_out;
  wire missing_start_error_out, missing_end_error_out, burst_rule_error_out;
  wire [63:0] local_bus_data_out;
  wire [3:0] local_bus_chan_out;
  wire [11:0] lane_word_locked_out, metaframe_word_error_out, framing_error_out;
  int err_total = 0, comparisons = 0, i;
  logic [70:0] q[$];
  logic [68:0] hold;
  bit opn[16], perr[16], pend[16], hv, xf, full_seen, f;
  logic [3:0] cch = 0, xp;
  int dc = 0, sp = 999;

  ilrm_rx_error_monitor dut_u (.*);
  ilrm_user_sink sink_u (.clk_in(clk_in), .stall_in(stall), .ready_out(local_bus_ready_in));

  always #25 clk_in = ~clk_in;

  task chk(input string n, input logic [71:0] e, input logic [71:0] s);
    comparisons++;
    if (e !== s) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task push(input bit e);
    q.push_back({hold, e, e & perr[hold[68:65]]});
  endtask

  // Offer one word, hold it until taken, then update the expected stream
  task put(input bit c, b, s, e, input logic [3:0] ch, input bit bad);
    logic [31:0] r;
    bit br;
    r = $urandom;
    ctl_valid_in <= c; data_valid_in <= !c; ctl_burst_in <= b; ctl_sop_in <= s; ctl_eop_in <= e;
    ctl_chan_in <= ch; ctl_crc_rcvd_in <= r[23:0]; ctl_crc_calc_in <= r[23:0] ^ {23'h0, bad};
    data_word_in <= {$urandom, r};
    do @(negedge clk_in); while (!word_ready_out);
    @(posedge clk_in);
    xp = 0;
    if (c) begin
      br = (!e && dc % 8 != 0) || (b && sp < burst_short_bytes_in / 8);
      xp = {bad, 2'b00, br};
      if (bad || br) foreach (opn[k]) if (opn[k]) perr[k] = 1;
      if (hv) push(e);
      hv = 0;
      if (e) begin opn[cch] = 0; perr[cch] = 0; end
      if (b) begin cch = ch; sp = 0; end
      if (s && opn[ch]) begin xp[1] = 1; perr[ch] = 1; end
      else if (s) begin opn[ch] = 1; pend[ch] = 1; end
      dc = 0;
    end else begin
      if (hv) push(0);
      if (!opn[cch]) begin xp[2] = 1; opn[cch] = 1; perr[cch] = 1; pend[cch] = 1; end
      hold = {cch, pend[cch], data_word_in};
      pend[cch] = 0; hv = 1; dc++;
    end
    // Spacing counts the words after a burst control word, not the word itself
    if (!(c && b)) sp++;
    xf = 1;
  endtask

  task dat(input int n);
    repeat (n) put(0, 0, 0, 0, 0, 0);
  endtask

  task pkt(input logic [3:0] ch, input int n);
    put(1, 1, 1, 0, ch, 0);
    dat(n);
    put(1, 0, 0, 1, ch, 0);
  endtask

  task step(input int n);
    ctl_valid_in <= 0; data_valid_in <= 0; align_attempt_fail_in <= 0;
    repeat (n) @(posedge clk_in);
  endtask

  always @(negedge clk_in) begin
    if (!word_ready_out) full_seen = 1;
    if (xf) chk("pulses", xp,
                {control_word_check_error_out, missing_start_error_out, missing_end_error_out,
                 burst_rule_error_out});
    xf = 0;
  end

  always @(posedge clk_in) if (local_bus_valid_out && local_bus_ready_in) begin
    chk("word", q.pop_front(), {local_bus_chan_out, local_bus_sop_out, local_bus_data_out, local_bus_eop_out,
        packet_error_out & local_bus_eop_out});
  end

  initial begin
    #1_000_000;
    err_total++;
    close_out;
  end

  initial begin
    void'($urandom(32'h3E86));
    repeat (3) @(posedge clk_in);
    nrst_in <= 1;
    lane_boundary_sync_in <= 12'hFFF; lane_ctl_words_ok_in <= 12'h7FF;
    step(2);
    @(negedge clk_in) chk("locked", 12'h7FF, lane_word_locked_out);
    @(posedge clk_in) begin lane_sync_word_bad_in <= 12'h820; lane_framing_bad_in <= 12'h810; end
    @(posedge clk_in) begin lane_sync_word_bad_in <= 0; lane_framing_bad_in <= 0; end
    @(negedge clk_in) chk("meta", 12'h020, metaframe_word_error_out);
    chk("framing", {12'h010, 1'b0}, {framing_error_out, control_word_check_error_out});
    @(posedge clk_in) begin lane_ctl_words_ok_in <= 12'hFFF; lanes_deskew_done_in <= 1; rx_enable_in <= 1; end
    step(3);
    @(negedge clk_in) chk("deskewed", 1, lanes_deskewed_out);
    @(posedge clk_in) lane_framing_bad_in <= 12'h001;
    @(posedge clk_in) lane_framing_bad_in <= 0;
    @(negedge clk_in) chk("framing check", 1, control_word_check_error_out);
    // Words are offered just after a rising edge, so each one is taken exactly once
    @(posedge clk_in);
    for (i = 0; i < 6; i++) pkt($urandom % 16, 1 + $urandom % 12);
    put(1, 1, 1, 0, 5, 0); dat(8); put(1, 1, 1, 0, 2, 0); dat(8);
    put(1, 0, 0, 0, 2, 1); dat(2); put(1, 0, 0, 1, 2, 0);
    put(1, 1, 0, 0, 5, 0); dat(1); put(1, 0, 0, 1, 5, 0);
    put(1, 1, 0, 0, 7, 0); dat(3); put(1, 0, 0, 1, 7, 0);
    put(1, 1, 1, 0, 9, 0); dat(8); put(1, 1, 1, 0, 9, 0); dat(3); put(1, 0, 0, 1, 9, 0);
    put(1, 1, 1, 0, 1, 0); dat(3); put(1, 1, 0, 0, 1, 0); dat(1); put(1, 0, 0, 1, 1, 0);
    burst_short_bytes_in <= 9'h040;
    put(1, 1, 1, 0, 4, 0); put(1, 1, 0, 0, 4, 0); dat(2); put(1, 0, 0, 1, 4, 0);
    burst_short_bytes_in <= 0;
    fork begin stall <= 1; repeat (20) @(posedge clk_in); stall <= 0; end join_none
    pkt(3, 6);
    step(1);
    for (i = 0; i < 200 && q.size() > 0; i++) @(posedge clk_in);
    chk("drained", {1'b1, 32'd0}, {full_seen, q.size()});
    rx_enable_in <= 0;
    f = 0;
    repeat (3) @(negedge clk_in) f |= deskew_failure_out;
    chk("loss", 1, f);
    // One-cycle attempt pulses; the failure level follows the count one edge later
    for (i = 0; i < 4; i++) begin
      @(posedge clk_in) align_attempt_fail_in <= 1;
      @(posedge clk_in) align_attempt_fail_in <= 0;
      repeat (2) @(negedge clk_in);
      if (i == 2) chk("three tries", 0, deskew_failure_out);
    end
    @(negedge clk_in) chk("four tries", 1, deskew_failure_out);
    close_out;
  end
endmodule // ilrm_rx_error_monitor_tb
